/* inc/acfg_defines.svh */
// Purpose: register offsets, field positions, masks and reset values of the config bank
// Assumes: included by its bare name
// Notes: masks clear the open bit positions on write
`ifndef ACFG_DEFINES_SVH
`define ACFG_DEFINES_SVH

// ==========================================================
// register offsets
`define ACFG_A_CHAN 9'h005
`define ACFG_A_PWR 9'h008
`define ACFG_A_CHOP 9'h00c
`define ACFG_A_OFMT 9'h014
`define ACFG_A_ADJ 9'h015
`define ACFG_A_PHASE 9'h016
`define ACFG_A_COMMIT 9'h0ff
`define ACFG_A_OVR 9'h100

// ==========================================================
// writable bit masks
`define ACFG_M_CHAN 8'h33
`define ACFG_M_PWR 8'h03
`define ACFG_M_CHOP 8'h04
`define ACFG_M_OFMT 8'h45
`define ACFG_M_TERM 8'h30
`define ACFG_M_PHASE 8'h7f
`define ACFG_M_OVR 8'h77

// ==========================================================
// field positions
`define ACFG_CHAN_DATA0 0
`define ACFG_CHAN_FCO 4
`define ACFG_PWR_HI 1
`define ACFG_PWR_LO 0
`define ACFG_CHOP_BIT 2
`define ACFG_OFMT_STD 6
`define ACFG_OFMT_INV 2
`define ACFG_OFMT_TWOS 0
`define ACFG_TERM_HI 5
`define ACFG_TERM_LO 4
`define ACFG_ADJ_DRV 0
`define ACFG_PH_IN_HI 6
`define ACFG_PH_IN_LO 4
`define ACFG_PH_OUT_HI 3
`define ACFG_PH_OUT_LO 0
`define ACFG_COMMIT_BIT 0
`define ACFG_SAMP_MSB 11

// ==========================================================
// reset values and limits
`define ACFG_RST_ZERO 8'h00
`define ACFG_RST_OFMT 8'h01
`define ACFG_RST_PHASE 8'h03
`define ACFG_PH_OUT_MAX 4'hb
`define ACFG_CNT_ZERO 3'h0

`endif

/* inc/acfg_pkg.sv */
// Purpose: types shared by the config bank and its sample phase counter
// Assumes: offsets and positions come from acfg_defines.svh
// Notes: none
package acfg_pkg;

	// ==========================================================
	// register access request from the serial control port decoder
	typedef struct packed {
		logic wr;
		logic rd;
		logic [8:0] addr;
		logic [7:0] wdata;
	} acfg_req_t;

	// ==========================================================
	// datapath power controls
	typedef struct packed {
		logic clk_en;
		logic dp_reset;
		logic out_en;
		logic out_reset;
	} acfg_pwr_t;

	// power-mode field decode, in field order
	typedef enum logic [1:0] {
		PM_NORMAL,
		PM_PDOWN,
		PM_STANDBY,
		PM_DRESET
	} acfg_pmode_t;

	// one sample word per data channel
	typedef logic [1:0][11:0] acfg_pair_t;

endpackage : acfg_pkg

/* rtl/acfg_phase_delay.sv */
// Purpose: picks the input clock cycle on which sampling happens under the divider
// Assumes: phase never above the divider ratio
// Notes: without the divider every input clock tick samples
`timescale 1ns/1ps
`include "acfg_defines.svh"
module acfg_phase_delay (
	input wire logic clk,
	input wire logic resetn,
	input wire logic hold,
	input wire logic in_tick,
	input wire logic div_active,
	input wire logic [2:0] div_ratio,
	input wire logic [2:0] phase,
	output logic sample_tick_ff
);
	import acfg_pkg::*;

	logic [2:0] cnt_ff;
	logic [2:0] nxt_cnt;
	logic at_end;
	logic hit;

	// ==========================================================
	// divider cycle counter and phase match
	assign at_end = (cnt_ff == div_ratio);
	assign nxt_cnt = at_end ? `ACFG_CNT_ZERO : 3'(cnt_ff + 3'h1);
	assign hit = div_active ? (cnt_ff == phase) : 1'b1;

	// counter cleared to zero while the datapath is in reset
	always_ff @(posedge clk) begin
		if (!resetn || hold) begin
			cnt_ff <= `ACFG_CNT_ZERO;
			sample_tick_ff <= 1'b0;
		end else begin
			sample_tick_ff <= in_tick & hit;
			if (in_tick) begin
				cnt_ff <= nxt_cnt;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn || hold);

	phase_delay_a: assert property (in_tick && div_active && cnt_ff != phase |=>
		!sample_tick_ff)
		else $error("sample taken off the programmed phase");

endmodule : acfg_phase_delay

/* rtl/acfg_regs.sv */
// Purpose: output, power and clock configuration register bank of a dual converter
// Assumes: serial port decoder delivers one-cycle read and write requests
// Notes: per-channel data features follow the channel index; the control port resets only on resetn
//
// What this block does
// - index bits 1:0 choose which data channels take per-channel writes
// - index also selects clock outputs, which take only the drive setting
// - all registers but the rate override act at once on write
// - commit bit 0 loads the pending rate override into the active copy
// - power mode 00 runs both channels normally
// - mode 01 gates datapath clocks, resets datapath, disables outputs
// - mode 10 gates clocks and disables outputs, no datapath reset
// - mode 11 resets datapath clocks and outputs, control port untouched
// - control port always usable, reset only by power-on reset
// - chop enable bit moves offsets to half the sample clock
// - standard bit picks normal range or reduced range output levels
// - invert bit flips every bit of the serial output stream
// - format bit set gives two's complement, cleared gives offset binary
// - termination field selects internal output termination resistor
// - drive bit doubles frame and data clock drive of selected clock output
// - termination selection wins over doubled clock drive
// - input phase delays sampling by that many input clocks under divider
// - output clock phase steps 60 degrees per code, reset code 0011
`timescale 1ns/1ps
`include "acfg_defines.svh"
module acfg_regs (
	input wire logic clk,
	input wire logic resetn,
	input acfg_pkg::acfg_req_t req,
	input wire logic in_tick,
	input wire logic div_active,
	input wire logic [2:0] div_ratio,
	input acfg_pkg::acfg_pair_t sample,
	output logic [7:0] rdata_ff,
	output logic rvalid_ff,
	output acfg_pkg::acfg_pwr_t pwr_out_ff,
	output logic chop_en_ff,
	output logic lvds_ieee_ff,
	output logic [1:0] term_sel_ff,
	output logic fco_drive_2x_ff,
	output logic dco_drive_2x_ff,
	output logic [3:0] dco_phase_ff,
	output logic [7:0] ovr_active_ff,
	output acfg_pkg::acfg_pair_t lanes_ff,
	output logic lanes_valid_ff
);
	import acfg_pkg::*;

	// ==========================================================
	// register storage
	logic [7:0] chan_ff;
	logic [7:0] pwr_ff;
	logic [7:0] chop_ff;
	logic [1:0][7:0] ofmt_ff;
	logic [7:0] term_ff;
	logic [1:0] drv_ff;
	logic [7:0] phase_ff;
	logic [7:0] ovr_pend_ff;
	logic sample_tick_ff;

	// ==========================================================
	// address decode
	logic wr_chan;
	logic wr_pwr;
	logic wr_chop;
	logic wr_ofmt;
	logic wr_adj;
	logic wr_phase;
	logic wr_commit;
	logic wr_ovr;
	logic do_commit;
	logic ph_ok;
	logic [7:0] nxt_phase;

	assign wr_chan = req.wr && req.addr == `ACFG_A_CHAN;
	assign wr_pwr = req.wr && req.addr == `ACFG_A_PWR;
	assign wr_chop = req.wr && req.addr == `ACFG_A_CHOP;
	assign wr_ofmt = req.wr && req.addr == `ACFG_A_OFMT;
	assign wr_adj = req.wr && req.addr == `ACFG_A_ADJ;
	assign wr_phase = req.wr && req.addr == `ACFG_A_PHASE;
	assign wr_commit = req.wr && req.addr == `ACFG_A_COMMIT;
	assign wr_ovr = req.wr && req.addr == `ACFG_A_OVR;
	assign do_commit = wr_commit && req.wdata[`ACFG_COMMIT_BIT];

	// reserved output phase codes leave the old code in place
	assign ph_ok = req.wdata[`ACFG_PH_OUT_HI:`ACFG_PH_OUT_LO] <= `ACFG_PH_OUT_MAX;
	assign nxt_phase = ph_ok ? (req.wdata & `ACFG_M_PHASE) :
		((req.wdata & `ACFG_M_PHASE & ~8'h0f) | (phase_ff & 8'h0f));

	// ==========================================================
	// global registers, written at once and reset only by resetn
	always_ff @(posedge clk) begin
		if (!resetn) begin
			chan_ff <= `ACFG_RST_ZERO;
			pwr_ff <= `ACFG_RST_ZERO;
			chop_ff <= `ACFG_RST_ZERO;
			term_ff <= `ACFG_RST_ZERO;
			phase_ff <= `ACFG_RST_PHASE;
			ovr_pend_ff <= `ACFG_RST_ZERO;
			ovr_active_ff <= `ACFG_RST_ZERO;
		end else begin
			if (wr_chan) chan_ff <= req.wdata & `ACFG_M_CHAN;
			if (wr_pwr) pwr_ff <= req.wdata & `ACFG_M_PWR;
			if (wr_chop) chop_ff <= req.wdata & `ACFG_M_CHOP;
			if (wr_adj) term_ff <= req.wdata & `ACFG_M_TERM;
			if (wr_phase) phase_ff <= nxt_phase;
			if (wr_ovr) ovr_pend_ff <= req.wdata & `ACFG_M_OVR;
			if (do_commit) ovr_active_ff <= ovr_pend_ff;
		end
	end

	// ==========================================================
	// per data channel format registers
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_dch
			logic sel;
			logic [7:0] nxt_ofmt;
			assign sel = chan_ff[`ACFG_CHAN_DATA0 + g];
			// standard bit is global, invert and format follow the index
			assign nxt_ofmt = sel ? (req.wdata & `ACFG_M_OFMT) :
				((ofmt_ff[g] & ~(8'h01 << `ACFG_OFMT_STD)) |
				(req.wdata & (8'h01 << `ACFG_OFMT_STD)));
			always_ff @(posedge clk) begin
				if (!resetn) begin
					ofmt_ff[g] <= `ACFG_RST_OFMT;
				end else if (wr_ofmt) begin
					ofmt_ff[g] <= nxt_ofmt;
				end
			end
		end
		// clock outputs take only the drive bit
		for (g = 0; g < 2; g++) begin : g_cch
			always_ff @(posedge clk) begin
				if (!resetn) begin
					drv_ff[g] <= 1'b0;
				end else if (wr_adj && chan_ff[`ACFG_CHAN_FCO + g]) begin
					drv_ff[g] <= req.wdata[`ACFG_ADJ_DRV];
				end
			end
		end
	endgenerate

	// ==========================================================
	// read back, lowest selected channel answers per-channel reads
	logic sel_d;
	logic sel_c;
	logic [7:0] adj_rd;
	logic [7:0] rd_sel;

	assign sel_d = !chan_ff[`ACFG_CHAN_DATA0] && chan_ff[`ACFG_CHAN_DATA0 + 1];
	assign sel_c = !chan_ff[`ACFG_CHAN_FCO] && chan_ff[`ACFG_CHAN_FCO + 1];
	assign adj_rd = term_ff | (8'(drv_ff[sel_c]) << `ACFG_ADJ_DRV);
	assign rd_sel = (req.addr == `ACFG_A_CHAN) ? chan_ff :
		(req.addr == `ACFG_A_PWR) ? pwr_ff :
		(req.addr == `ACFG_A_CHOP) ? chop_ff :
		(req.addr == `ACFG_A_OFMT) ? ofmt_ff[sel_d] :
		(req.addr == `ACFG_A_ADJ) ? adj_rd :
		(req.addr == `ACFG_A_PHASE) ? phase_ff :
		(req.addr == `ACFG_A_OVR) ? ovr_pend_ff :
		`ACFG_RST_ZERO;

	// answer every read regardless of power mode
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rdata_ff <= `ACFG_RST_ZERO;
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= req.rd;
			rdata_ff <= req.rd ? rd_sel : `ACFG_RST_ZERO;
		end
	end

	// ==========================================================
	// power mode decode
	acfg_pmode_t pmode;
	acfg_pwr_t nxt_pwr;

	assign pmode = acfg_pmode_t'(pwr_ff[`ACFG_PWR_HI:`ACFG_PWR_LO]);

	always_comb begin
		nxt_pwr = '0;
		case (pmode)
			PM_NORMAL: begin
				nxt_pwr.clk_en = 1'b1;
				nxt_pwr.out_en = 1'b1;
			end
			PM_PDOWN: begin
				nxt_pwr.dp_reset = 1'b1;
			end
			PM_STANDBY: begin
				nxt_pwr.dp_reset = 1'b0;
			end
			PM_DRESET: begin
				nxt_pwr.dp_reset = 1'b1;
				nxt_pwr.out_reset = 1'b1;
			end
			default: begin
				nxt_pwr = '0;
			end
		endcase
	end

	// ==========================================================
	// static settings driven to the analog and output logic
	logic term_on;

	assign term_on = term_ff[`ACFG_TERM_HI:`ACFG_TERM_LO] != 2'h0;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			pwr_out_ff <= '0;
			chop_en_ff <= 1'b0;
			lvds_ieee_ff <= 1'b0;
			term_sel_ff <= 2'h0;
			fco_drive_2x_ff <= 1'b0;
			dco_drive_2x_ff <= 1'b0;
			dco_phase_ff <= 4'(`ACFG_RST_PHASE);
		end else begin
			pwr_out_ff <= nxt_pwr;
			chop_en_ff <= chop_ff[`ACFG_CHOP_BIT];
			lvds_ieee_ff <= ofmt_ff[0][`ACFG_OFMT_STD];
			term_sel_ff <= term_ff[`ACFG_TERM_HI:`ACFG_TERM_LO];
			fco_drive_2x_ff <= drv_ff[0] && !term_on;
			dco_drive_2x_ff <= drv_ff[1] && !term_on;
			dco_phase_ff <= phase_ff[`ACFG_PH_OUT_HI:`ACFG_PH_OUT_LO];
		end
	end

	// ==========================================================
	// sampling phase under the clock divider
	acfg_phase_delay u_phase (
		.clk(clk),
		.resetn(resetn),
		.hold(pwr_out_ff.dp_reset),
		.in_tick(in_tick),
		.div_active(div_active),
		.div_ratio(div_ratio),
		.phase(phase_ff[`ACFG_PH_IN_HI:`ACFG_PH_IN_LO]),
		.sample_tick_ff(sample_tick_ff)
	);

	// ==========================================================
	// output word shaping per data channel
	acfg_pair_t shaped;

	generate
		for (g = 0; g < 2; g++) begin : g_shape
			logic [11:0] fmt;
			assign fmt = ofmt_ff[g][`ACFG_OFMT_TWOS] ? sample[g] :
				(sample[g] ^ (12'h001 << `ACFG_SAMP_MSB));
			assign shaped[g] = ofmt_ff[g][`ACFG_OFMT_INV] ? ~fmt : fmt;
		end
	endgenerate

	// lanes cleared in reset, frozen with clocks gated, held with valid low when disabled
	always_ff @(posedge clk) begin
		if (!resetn || pwr_out_ff.dp_reset || pwr_out_ff.out_reset) begin
			lanes_ff <= '0;
			lanes_valid_ff <= 1'b0;
		end else if (!pwr_out_ff.out_en) begin
			lanes_valid_ff <= 1'b0;
		end else if (pwr_out_ff.clk_en) begin
			lanes_valid_ff <= sample_tick_ff;
			if (sample_tick_ff) lanes_ff <= shaped;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_mode(logic [1:0] m);
		pwr_ff[`ACFG_PWR_HI:`ACFG_PWR_LO] == m;
	endsequence

	sequence s_pwr_write(logic [1:0] m);
		wr_pwr && req.wdata[`ACFG_PWR_HI:`ACFG_PWR_LO] == m ##1 s_mode(m);
	endsequence

	normal_mode_a: assert property (s_pwr_write(2'h0) |=>
		pwr_out_ff.clk_en && pwr_out_ff.out_en && !pwr_out_ff.dp_reset)
		else $error("normal mode did not enable datapath");
	pdown_mode_a: assert property (s_pwr_write(2'h1) |=>
		!pwr_out_ff.clk_en && pwr_out_ff.dp_reset && !pwr_out_ff.out_en)
		else $error("power-down controls wrong");
	standby_mode_a: assert property (s_pwr_write(2'h2) |=>
		!pwr_out_ff.clk_en && !pwr_out_ff.dp_reset && !pwr_out_ff.out_en)
		else $error("standby controls wrong");
	dreset_mode_a: assert property (s_pwr_write(2'h3) |=>
		pwr_out_ff.dp_reset && pwr_out_ff.out_reset ##1 !lanes_valid_ff)
		else $error("digital reset did not reset outputs");
	port_alive_a: assert property (req.rd |=> rvalid_ff)
		else $error("read not answered");
	commit_load_a: assert property (do_commit |=> ovr_active_ff == $past(ovr_pend_ff))
		else $error("commit did not load override");
	override_held_a: assert property (!do_commit |=> $stable(ovr_active_ff))
		else $error("override took effect without commit");
	chop_immediate_a: assert property (wr_chop |=>
		##1 chop_en_ff == $past(req.wdata[`ACFG_CHOP_BIT], 2))
		else $error("chop enable not applied");
	chan_gate_a: assert property (wr_ofmt && !chan_ff[`ACFG_CHAN_DATA0] |=>
		ofmt_ff[0][`ACFG_OFMT_INV] == $past(ofmt_ff[0][`ACFG_OFMT_INV]))
		else $error("unselected channel changed");
	clk_subset_a: assert property (!wr_adj |=> $stable(drv_ff))
		else $error("clock channel took a data feature");
	term_wins_a: assert property (term_on |=> !fco_drive_2x_ff && !dco_drive_2x_ff)
		else $error("2x drive with termination selected");
	invert_out_a: assert property (
		sample_tick_ff && pwr_out_ff == nxt_pwr && nxt_pwr.out_en && ofmt_ff[0] == 8'h05 |=>
		lanes_ff[0] == ~$past(sample[0]))
		else $error("inverted stream wrong");
	reserved_phase_a: assert property (wr_phase && !ph_ok |=>
		phase_ff[`ACFG_PH_OUT_HI:`ACFG_PH_OUT_LO] ==
		$past(phase_ff[`ACFG_PH_OUT_HI:`ACFG_PH_OUT_LO]))
		else $error("reserved phase code stored");
	open_bits_a: assert property (req.rd && req.addr == `ACFG_A_PWR |=>
		rdata_ff[7:2] == 6'h00)
		else $error("open bits read nonzero");

endmodule : acfg_regs

/* test/acfg_host.sv */
// Purpose: host side of the serial control port, issuing register requests
// Assumes: one request at a time, driven just after the rising edge
// Notes: callers keep phase codes legal unless a test wants otherwise
`timescale 1ns/1ps
module acfg_host (
	input wire logic clk,
	input wire logic rvalid,
	input wire logic [7:0] rdata,
	output acfg_pkg::acfg_req_t req
);
	import acfg_pkg::*;

	initial req = '0;

	// ==========================================================
	// write: held one cycle, taken at the next edge
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		req <= '0;
	endtask : wr

	// ==========================================================
	// read: answer taken just after the taking edge, while the one-cycle pulse stands
	task automatic rd(input logic [8:0] a, output logic [7:0] d);
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		req <= '0;
		#1;
		d = (rvalid === 1'b1) ? rdata : 8'hxx; // missing answer never matches
	endtask : rd
endmodule : acfg_host

/* test/tb_top.sv */
// Purpose: self-checking bench for the output and power config bank
// Assumes: host model drives the register port
// Notes: random data from a fixed seed, corner cases written by hand
`timescale 1ns/1ps
`include "acfg_defines.svh"
module tb_top;
	import acfg_pkg::*;

	// ==========================================================
	// signals
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic in_tick = 1'b0;
	logic div_active = 1'b0;
	logic [2:0] div_ratio = 3'h0;
	acfg_pair_t sample = '0;
	acfg_req_t req;
	logic [7:0] rdata_ff, ovr_active_ff;
	logic rvalid_ff, chop_en_ff, lvds_ieee_ff, fco_drive_2x_ff, dco_drive_2x_ff, lanes_valid_ff;
	acfg_pwr_t pwr_out_ff;
	logic [1:0] term_sel_ff;
	logic [3:0] dco_phase_ff;
	acfg_pair_t lanes_ff;
	int n_mismatch = 0;
	int num_checks = 0;
	localparam logic [3:0] PWR_EXP [4] = '{4'ha, 4'h4, 4'h0, 4'h5};

	// 40 MHz clock
	always #12.5 clk = ~clk;

	acfg_regs dut_u (.clk(clk), .resetn(resetn), .req(req), .in_tick(in_tick),
		.div_active(div_active), .div_ratio(div_ratio), .sample(sample),
		.rdata_ff(rdata_ff), .rvalid_ff(rvalid_ff), .pwr_out_ff(pwr_out_ff),
		.chop_en_ff(chop_en_ff), .lvds_ieee_ff(lvds_ieee_ff), .term_sel_ff(term_sel_ff),
		.fco_drive_2x_ff(fco_drive_2x_ff), .dco_drive_2x_ff(dco_drive_2x_ff),
		.dco_phase_ff(dco_phase_ff), .ovr_active_ff(ovr_active_ff), .lanes_ff(lanes_ff),
		.lanes_valid_ff(lanes_valid_ff));

	acfg_host host_u (.clk(clk), .rvalid(rvalid_ff), .rdata(rdata_ff), .req(req));

	// ==========================================================
	// compare and helper tasks
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_reg

	task automatic chk_lanes(input acfg_pair_t got, input acfg_pair_t exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_lanes

	task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host_u.rd(a, d);
		chk_reg(d, exp);
	endtask : rd_chk

	// let derived outputs follow a write
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask : settle

	// one converter word, then count valid pulses
	task automatic pulse(output int n);
		n = 0;
		@(posedge clk);
		in_tick <= 1'b1;
		sample <= acfg_pair_t'($urandom);
		@(posedge clk);
		in_tick <= 1'b0;
		repeat (4) begin
			@(posedge clk);
			#1;
			if (lanes_valid_ff === 1'b1) n++;
		end
	endtask : pulse

	// expected shaping of one word
	function automatic logic [11:0] shape(input logic [11:0] s, input logic fmt,
		input logic inv);
		logic [11:0] v;
		v = s;
		if (!fmt) v[11] = ~v[11];
		if (inv) v = ~v;
		return v;
	endfunction : shape

	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run

	// watchdog, about seventy times the expected run
	initial begin
		#(25 * 20000);
		n_mismatch++;
		complete_run();
	end

	// ==========================================================
	// main sequence
	initial begin
		int seed, n;
		logic [7:0] v, p;
		seed = $urandom(32'h5e72);
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		#1;
		chk_reg({4'h0, dco_phase_ff}, `ACFG_RST_PHASE);
		chk_reg({4'h0, pwr_out_ff}, {4'h0, PWR_EXP[0]});
		rd_chk(`ACFG_A_OFMT, `ACFG_RST_OFMT);
		rd_chk(`ACFG_A_PHASE, `ACFG_RST_PHASE);
		rd_chk(`ACFG_A_COMMIT, 8'h00);
		rd_chk(9'h0aa, 8'h00);
		$display("test reset done");

		// random writes, masked readback
		for (int i = 0; i < 8; i++) begin
			v = 8'($urandom);
			host_u.wr(`ACFG_A_CHOP, v);
			rd_chk(`ACFG_A_CHOP, v & `ACFG_M_CHOP);
			chk_reg({7'h0, chop_en_ff}, {7'h0, v[2]});
			p = 8'($urandom);
			host_u.wr(`ACFG_A_OVR, p);
			rd_chk(`ACFG_A_OVR, p & `ACFG_M_OVR);
			v = 8'($urandom);
			host_u.wr(`ACFG_A_CHAN, v);
			rd_chk(`ACFG_A_CHAN, v & `ACFG_M_CHAN);
		end
		$display("test masks done");

		// override waits for the commit bit
		chk_reg(ovr_active_ff, 8'h00);
		host_u.wr(`ACFG_A_COMMIT, 8'hfe);
		settle();
		chk_reg(ovr_active_ff, 8'h00);
		host_u.wr(`ACFG_A_COMMIT, 8'h01);
		settle();
		chk_reg(ovr_active_ff, p & `ACFG_M_OVR);
		$display("test override done");

		// every power mode, open bits set
		for (int m = 0; m < 4; m++) begin
			host_u.wr(`ACFG_A_PWR, 8'hfc | 8'(m));
			settle();
			chk_reg({4'h0, pwr_out_ff}, {4'h0, PWR_EXP[m]});
			rd_chk(`ACFG_A_PWR, 8'(m));
			pulse(n);
			chk_reg(8'(n), (m == 0) ? 8'h01 : 8'h00);
		end
		host_u.wr(`ACFG_A_PWR, 8'h03);
		host_u.wr(`ACFG_A_PWR, 8'h00);
		settle();
		chk_reg({4'h0, pwr_out_ff}, {4'h0, PWR_EXP[0]});
		$display("test power done");

		// number format and inversion on both data channels
		host_u.wr(`ACFG_A_CHAN, 8'h03);
		for (int f = 0; f < 4; f++) begin
			host_u.wr(`ACFG_A_OFMT, {5'h0, f[1], 1'b0, f[0]});
			settle();
			pulse(n);
			chk_reg(8'(n), 8'h01);
			chk_lanes(lanes_ff, {shape(sample[1], f[0], f[1]), shape(sample[0], f[0], f[1])});
		end
		// divider by one, phase zero: every tick samples
		@(posedge clk);
		div_active <= 1'b1;
		pulse(n);
		chk_reg(8'(n), 8'h01);
		// divider by two, phase one: only every second tick samples
		host_u.wr(`ACFG_A_PHASE, 8'h13);
		div_ratio <= 3'h1;
		pulse(n);
		chk_reg(8'(n), 8'h00);
		pulse(n);
		chk_reg(8'(n), 8'h01);
		$display("test datapath done");

		// per-channel writes and the global standard bit
		host_u.wr(`ACFG_A_CHAN, 8'h02);
		host_u.wr(`ACFG_A_OFMT, 8'h44);
		rd_chk(`ACFG_A_OFMT, 8'h44);
		host_u.wr(`ACFG_A_CHAN, 8'h01);
		rd_chk(`ACFG_A_OFMT, 8'h45);
		chk_reg({7'h0, lvds_ieee_ff}, 8'h01);

		// clock output drive and termination precedence
		host_u.wr(`ACFG_A_CHAN, 8'h10);
		host_u.wr(`ACFG_A_ADJ, 8'h01);
		settle();
		chk_reg({6'h0, fco_drive_2x_ff, dco_drive_2x_ff}, 8'h02);
		host_u.wr(`ACFG_A_CHAN, 8'h20);
		host_u.wr(`ACFG_A_ADJ, 8'h11);
		settle();
		chk_reg({4'h0, fco_drive_2x_ff, dco_drive_2x_ff, term_sel_ff}, 8'h01);
		$display("test channels done");

		// output clock phase, top code then a reserved one
		host_u.wr(`ACFG_A_PHASE, 8'h0b);
		settle();
		chk_reg({4'h0, dco_phase_ff}, {4'h0, `ACFG_PH_OUT_MAX});
		host_u.wr(`ACFG_A_PHASE, 8'h1c);
		rd_chk(`ACFG_A_PHASE, 8'h1b);
		chk_reg({4'h0, dco_phase_ff}, {4'h0, `ACFG_PH_OUT_MAX});
		$display("test phase done");
		complete_run();
	end
endmodule : tb_top
